// ==== dtf_ctrl_model.sv ====
// Memory controller model that drives the link pins of the training block
`timescale 1ns/1ps
module dtf_ctrl_model
	import dtf_pkg::*;
(
	// Clock
	input  wire logic             mclk,
	// Link pins
	output logic                  link_ck,
	output logic                  link_cke,
	output logic                  link_reset_n,
	output logic [2:0]            link_cmd,
	output logic [6:0]            link_op,
	output logic [DQ_W-1:0]       dq_in,
	output logic [MASK_W-1:0]     mask_in,
	// Device outputs
	input  wire logic [DQ_W-1:0]  dq_out,
	input  wire logic [DQ_W-1:0]  dq_oe_n,
	input  wire logic [MASK_W-1:0] mask_out,
	input  wire logic [MASK_W-1:0] mask_oe_n
);
	logic [LANES-1:0] beats [$];
	logic [LANES-1:0] oens [$];

	initial begin
		link_ck = 1'b1;
		link_cke = 1'b1;
		link_reset_n = 1'b1;
		link_cmd = CMD_DES;
		link_op = 7'h00;
		{mask_in, dq_in} = '0;
	end

	// ------------------------------------------------------------
	// One link period of 8 mclk; clock stands high between calls
	// ------------------------------------------------------------
	task automatic cyc(input logic [2:0] c, input logic [6:0] o,
			input logic wr, input logic [LANES-1:0] v);
		@(posedge mclk);
		link_ck <= 1'b0;
		link_cmd <= c;
		link_op <= o;
		// Released lines toggle so stale data cannot pass
		{mask_in, dq_in} <= wr ? v : ~{mask_in, dq_in};
		repeat (4) @(posedge mclk);
		beats.push_back({mask_out, dq_out});
		oens.push_back({mask_oe_n, dq_oe_n});
		link_ck <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask

	task automatic train(input logic [6:0] o, input int lat,
			input logic wr, input logic [LANES-1:0] d [16]);
		beats.delete();
		oens.delete();
		cyc(CMD_MULTI, o, 1'b0, '0);
		cyc(CMD_CAS2, 7'h00, 1'b0, '0);
		for (int i = 0; i < lat + 19; i++)
			cyc(CMD_DES, 7'h00, wr && i > lat && i <= lat + 16,
				d[(i + 15 - lat) % 16]);
	endtask

	task automatic pulse(input logic pin_rst);
		@(posedge mclk);
		if (pin_rst)
			link_reset_n <= 1'b0;
		else
			link_cke <= 1'b0;
		repeat (16) @(posedge mclk);
		link_reset_n <= 1'b1;
		link_cke <= 1'b1;
	endtask
endmodule // dtf_ctrl_model

// ==== dtf_pkg.sv ====
// Constants and types shared by the training block, the controller model and the bench
package dtf_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CAL_FIRST   = 8'h00;
	localparam logic [7:0] ADDR_CAL_SECOND  = 8'h04;
	localparam logic [7:0] ADDR_INV_LOWER   = 8'h08;
	localparam logic [7:0] ADDR_INV_UPPER   = 8'h0c;
	localparam logic [7:0] ADDR_MASK_CFG    = 8'h10;
	localparam logic [7:0] ADDR_INV_CFG     = 8'h14;
	localparam logic [7:0] ADDR_RD_LAT      = 8'h18;
	localparam logic [7:0] ADDR_WR_LAT      = 8'h1c;
	localparam logic [7:0] ADDR_STATUS      = 8'h20;

	localparam logic [7:0] RST_CAL_FIRST    = 8'h5a;
	localparam logic [7:0] RST_CAL_SECOND   = 8'h3c;
	localparam logic [7:0] RST_INV_MASK     = 8'h55;
	localparam logic [7:0] RST_CFG          = 8'h00;
	localparam logic [5:0] RST_LAT          = 6'h06;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DM_DISABLE_BIT  = 5;
	localparam int WR_INV_BIT      = 7;
	localparam int RD_INV_BIT      = 6;
	localparam int ST_WR_PTR_LSB   = 0;
	localparam int ST_RD_PTR_LSB   = 4;
	localparam int ST_BUSY_BIT     = 8;
	localparam int OP_ENABLE_BIT   = 6;

	// ----------------------------------------------------------------
	// Link command codes and training operands
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_DES     = 3'h0;
	localparam logic [2:0] CMD_MULTI   = 3'h1;
	localparam logic [2:0] CMD_CAS2    = 3'h2;
	localparam logic [2:0] CMD_WRITE   = 3'h3;
	localparam logic [2:0] CMD_MWRITE  = 3'h4;
	localparam logic [2:0] CMD_READ    = 3'h5;
	localparam logic [2:0] CMD_READ_AP = 3'h6;
	localparam logic [2:0] CMD_MODE_RD = 3'h7;

	localparam logic [6:0] OP_RD_FIFO  = 7'h41;
	localparam logic [6:0] OP_WR_FIFO  = 7'h42;
	localparam logic [6:0] OP_RD_CAL   = 7'h43;

	// ----------------------------------------------------------------
	// Burst and FIFO geometry
	// ----------------------------------------------------------------
	localparam int          DQ_W       = 16;
	localparam int          MASK_W     = 2;
	localparam int          LANES      = DQ_W + MASK_W;
	localparam int          BURST_LEN  = 16;
	localparam int          FIFO_DEPTH = 5;
	localparam logic [2:0]  LAST_ENTRY = 3'h4;
	localparam logic [3:0]  LAST_BEAT  = 4'hf;

	typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_BURST} dtf_phase_t;
	typedef enum logic [1:0] {K_RDCAL, K_RDFIFO, K_WRFIFO} dtf_kind_t;

endpackage

// ==== dtf_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dtf_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Asynchronous input and filtered level
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} dtf_sync_t;

	dtf_sync_t st_q;
	dtf_sync_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// Change accepted only once stages two and three agree
		if (st_q.s2 == st_q.s3) begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// Preload the pin level so no false edge follows reset
			st_q <= '{din, din, din, din};
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.lvl;
endmodule // dtf_sync

// ==== dtf_training.sv ====
// DRAM-side read calibration pattern and write/read training FIFO
// Summary of operation
// [RL1] Calibration sends first byte then second byte, LSB first, on all lanes.
// [RL2] Data lanes invert per mask bit; mask lanes are never inverted.
// [RL3] Mask lanes float only if masking off and both inversions off.
// [RL4] No bus inversion is applied to calibration output.
// [RL5] Controller waits activate-to-column delay after power-down exit.
// [RL6] Multi-purpose command with operand bit 6 low is a no-operation.
// [RL7] Controller follows training commands at once with a second column.
// [RL8] FIFO write uses write latency from edge after second column.
// [RL9] FIFO read uses read latency from edge after second column.
// [RL10] FIFO holds five sixteen-beat entries per lane.
// [RL11] Reading the FIFO leaves its contents unchanged.
// [RL12] Unwritten entries read back as whatever they hold.
// [RL13] Reads return entries zero to four, then wrap to zero.
// [RL14] Pointers reset at power-up, reset pin, power-down entries.
// [RL15] FIFO write advances write pointer; FIFO read advances read pointer.
// [RL16] Normal array reads advance both pointers.
// [RL17] Controller issues no array reads during write training.
// [RL18] Controller matches read count to write count plus depth multiples.
// [RL19] FIFO writes accepted in any bank, refresh or self-refresh state.
// [RL20] Controller spaces write to FIFO write; repeats at column interval.
// [RL21] A sixth FIFO write overwrites the first entry.
// [RL22] Controller reads FIFO straight after writing it, undisturbed.
// [RL23] Calibration burst follows read latency like a normal read.
// [RL24] Mask bits 0-3 to first four lanes, 4-7 to last four.
`timescale 1ns/1ps
module dtf_training
	import dtf_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Link pins
	input  wire logic              link_ck,
	input  wire logic              link_cke,
	input  wire logic              link_reset_n,
	input  wire logic [2:0]        link_cmd,
	input  wire logic [6:0]        link_op,
	// Data lanes
	input  wire logic [DQ_W-1:0]   dq_in,
	output logic      [DQ_W-1:0]   dq_out,
	output logic      [DQ_W-1:0]   dq_oe_n,
	input  wire logic [MASK_W-1:0] mask_inversion_lane_in,
	output logic      [MASK_W-1:0] mask_inversion_lane_out,
	output logic      [MASK_W-1:0] mask_inversion_lane_oe_n
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                            cal_first;
		logic [7:0]                            cal_second;
		logic [7:0]                            inv_lower;
		logic [7:0]                            inv_upper;
		logic [7:0]                            mask_cfg;
		logic [7:0]                            inv_cfg;
		logic [5:0]                            read_latency;
		logic [5:0]                            write_latency;
		logic [31:0]                           rdata;
		logic                                  err;
		logic                                  ck;
		logic                                  cke;
		logic                                  pend;
		dtf_kind_t                             pend_kind;
		dtf_phase_t                            phase;
		dtf_kind_t                             kind;
		logic [5:0]                            cnt;
		logic [3:0]                            beat;
		logic [2:0]                            idx;
		logic [2:0]                            wr_ptr;
		logic [2:0]                            rd_ptr;
		logic [FIFO_DEPTH-1:0][BURST_LEN-1:0][LANES-1:0] mem;
		logic [DQ_W-1:0]                       dq;
		logic [DQ_W-1:0]                       dq_oe_n;
		logic [MASK_W-1:0]                     mlane;
		logic [MASK_W-1:0]                     mlane_oe_n;
	} dtf_state_t;

	dtf_state_t st_q;
	dtf_state_t st_d;

	logic              ck_f;
	logic              cke_f;
	logic              pin_rst_n_f;
	logic [9:0]        cmd_f;
	logic [LANES-1:0]  din_f;
	logic              ck_rise;
	logic              cke_fall;
	logic [2:0]        cmd;
	logic [6:0]        op;
	logic              mlane_float;
	logic              pat_bit;
	logic              driving;
	logic              wr_acc;
	logic              rd_setup;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	dtf_sync #(.W(1)) u_sync_ck (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (link_ck),
		.dout  (ck_f)
	);
	dtf_sync #(.W(1)) u_sync_cke (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (link_cke),
		.dout  (cke_f)
	);
	dtf_sync #(.W(1)) u_sync_rst (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (~link_reset_n),
		.dout  (pin_rst_n_f)
	);
	dtf_sync #(.W(10)) u_sync_cmd (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   ({link_cmd, link_op}),
		.dout  (cmd_f)
	);
	dtf_sync #(.W(LANES)) u_sync_data (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   ({mask_inversion_lane_in, dq_in}),
		.dout  (din_f)
	);

	function automatic logic [2:0] ptr_next(input logic [2:0] p);
		ptr_next = (p == LAST_ENTRY) ? 3'h0 : p + 3'h1;
	endfunction

	// ----------------------------------------------------------------
	// Combinational decode
	// ----------------------------------------------------------------
	assign ck_rise  = ck_f & ~st_q.ck;
	assign cke_fall = st_q.cke & ~cke_f;
	assign cmd      = cmd_f[9:7];
	assign op       = cmd_f[6:0];
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign pready   = psel & penable;
	assign prdata   = st_q.rdata;
	assign pslverr  = st_q.err;

	assign mlane_float = st_q.mask_cfg[DM_DISABLE_BIT] & // [RL3]
		~st_q.inv_cfg[WR_INV_BIT] & ~st_q.inv_cfg[RD_INV_BIT];
	// Pattern bit is raw register content; no bus inversion logic exists
	assign pat_bit = st_q.beat[3] ? st_q.cal_second[st_q.beat[2:0]] // [RL1]
		: st_q.cal_first[st_q.beat[2:0]]; // [RL4]
	assign driving = (st_q.phase == PH_BURST) && (st_q.kind != K_WRFIFO);

	always_comb begin
		st_d     = st_q;
		st_d.ck  = ck_f;
		st_d.cke = cke_f;

		// ------------------------------------------------------------
		// APB slave: data latched in setup, write taken in access
		// ------------------------------------------------------------
		if (rd_setup) begin
			st_d.err   = 1'b0;
			st_d.rdata = 32'h0000_0000;
			case (paddr)
			ADDR_CAL_FIRST:  st_d.rdata[7:0] = st_q.cal_first;
			ADDR_CAL_SECOND: st_d.rdata[7:0] = st_q.cal_second;
			ADDR_INV_LOWER:  st_d.rdata[7:0] = st_q.inv_lower;
			ADDR_INV_UPPER:  st_d.rdata[7:0] = st_q.inv_upper;
			ADDR_MASK_CFG:   st_d.rdata[7:0] = st_q.mask_cfg;
			ADDR_INV_CFG:    st_d.rdata[7:0] = st_q.inv_cfg;
			ADDR_RD_LAT:     st_d.rdata[5:0] = st_q.read_latency;
			ADDR_WR_LAT:     st_d.rdata[5:0] = st_q.write_latency;
			ADDR_STATUS: begin
				st_d.rdata[ST_WR_PTR_LSB +: 3] = st_q.wr_ptr;
				st_d.rdata[ST_RD_PTR_LSB +: 3] = st_q.rd_ptr;
				st_d.rdata[ST_BUSY_BIT] = (st_q.phase != PH_IDLE);
			end
			default: st_d.err = 1'b1;
			endcase
		end
		if (wr_acc && pstrb[0]) begin
			case (paddr)
			ADDR_CAL_FIRST:  st_d.cal_first     = pwdata[7:0];
			ADDR_CAL_SECOND: st_d.cal_second    = pwdata[7:0];
			ADDR_INV_LOWER:  st_d.inv_lower     = pwdata[7:0];
			ADDR_INV_UPPER:  st_d.inv_upper     = pwdata[7:0];
			ADDR_MASK_CFG:   st_d.mask_cfg      = pwdata[7:0];
			ADDR_INV_CFG:    st_d.inv_cfg       = pwdata[7:0];
			ADDR_RD_LAT:     st_d.read_latency  = pwdata[5:0];
			ADDR_WR_LAT:     st_d.write_latency = pwdata[5:0];
			default: ;
			endcase
		end

		// ------------------------------------------------------------
		// Link sequencing, one step per link clock rising edge
		// ------------------------------------------------------------
		if (ck_rise) begin
			case (st_q.phase)
			PH_WAIT: begin
				if (st_q.cnt == 6'h00) begin
					st_d.phase = PH_BURST;
					st_d.beat  = 4'h0;
				end else begin
					st_d.cnt = st_q.cnt - 6'h01;
				end
			end
			PH_BURST: begin
				if (st_q.kind == K_WRFIFO) begin
					st_d.mem[st_q.idx][st_q.beat] = din_f; // [RL10] [RL21]
				end
				if (st_q.beat == LAST_BEAT) begin
					st_d.phase = PH_IDLE;
				end else begin
					st_d.beat = st_q.beat + 4'h1;
				end
			end
			default: ;
			endcase

			// A pending training command lives for one link edge only
			st_d.pend = 1'b0;
			case (cmd)
			CMD_MULTI: begin
				// Operand bit 6 low, or reserved operand: no effect
				if (op[OP_ENABLE_BIT] && st_q.phase == PH_IDLE) begin // [RL6]
					st_d.pend = (op == OP_RD_CAL) || (op == OP_RD_FIFO)
						|| (op == OP_WR_FIFO);
					st_d.pend_kind = (op == OP_RD_CAL) ? K_RDCAL
						: (op == OP_RD_FIFO) ? K_RDFIFO : K_WRFIFO;
				end
			end
			CMD_CAS2: begin
				if (st_q.pend) begin // [RL7]
					st_d.phase = PH_WAIT;
					st_d.kind  = st_q.pend_kind;
					st_d.idx   = 3'h0;
					st_d.cnt   = st_q.read_latency; // [RL9] [RL23]
					if (st_q.pend_kind == K_WRFIFO) begin // [RL19]
						st_d.cnt    = st_q.write_latency; // [RL8]
						st_d.idx    = st_q.wr_ptr;
						st_d.wr_ptr = ptr_next(st_q.wr_ptr); // [RL15]
					end else if (st_q.pend_kind == K_RDFIFO) begin
						st_d.idx    = st_q.rd_ptr; // [RL12]
						st_d.rd_ptr = ptr_next(st_q.rd_ptr); // [RL13]
					end
				end
			end
			CMD_READ, CMD_READ_AP: begin
				st_d.wr_ptr = ptr_next(st_q.wr_ptr); // [RL16]
				st_d.rd_ptr = ptr_next(st_q.rd_ptr);
			end
			default: ;
			endcase
		end

		// Power-down and self-refresh power-down entry both drop CKE
		if (cke_fall || pin_rst_n_f) begin
			st_d.wr_ptr = 3'h0; // [RL14]
			st_d.rd_ptr = 3'h0;
		end
		if (pin_rst_n_f) begin
			st_d.phase = PH_IDLE;
			st_d.pend  = 1'b0;
		end

		// ------------------------------------------------------------
		// Output lanes
		// ------------------------------------------------------------
		st_d.dq         = '0;
		st_d.mlane      = '0;
		st_d.dq_oe_n    = '1;
		st_d.mlane_oe_n = '1;
		if (driving) begin
			st_d.dq_oe_n = '0;
			if (!mlane_float) begin
				st_d.mlane_oe_n = '0; // [RL3]
			end
			if (st_q.kind == K_RDCAL) begin
				st_d.dq  = {DQ_W{pat_bit}} ^ // [RL2] [RL24]
					{st_q.inv_upper, st_q.inv_lower};
				st_d.mlane = {MASK_W{pat_bit}}; // [RL2]
			end else begin
				// Read-back leaves the stored entry untouched
				{st_d.mlane, st_d.dq} = // [RL11]
					st_q.mem[st_q.idx][st_q.beat];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q               <= '0; // [RL14]
			st_q.cal_first     <= RST_CAL_FIRST;
			st_q.cal_second    <= RST_CAL_SECOND;
			st_q.inv_lower     <= RST_INV_MASK;
			st_q.inv_upper     <= RST_INV_MASK;
			st_q.mask_cfg      <= RST_CFG;
			st_q.inv_cfg       <= RST_CFG;
			st_q.read_latency  <= RST_LAT;
			st_q.write_latency <= RST_LAT;
			st_q.dq_oe_n       <= '1;
			st_q.mlane_oe_n    <= '1;
			st_q.ck            <= ck_f;
		end else begin
			st_q <= st_d;
		end
	end

	assign dq_out                   = st_q.dq;
	assign dq_oe_n                  = st_q.dq_oe_n;
	assign mask_inversion_lane_out  = st_q.mlane;
	assign mask_inversion_lane_oe_n = st_q.mlane_oe_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_nop_multi: assert property ( // [RL6]
		(ck_rise && cmd == CMD_MULTI && !op[OP_ENABLE_BIT]
		&& !pin_rst_n_f)
		|=> !st_q.pend)
		else $error("Command with operand enable low was not ignored");

	chk_mlane_float: assert property ( // [RL3]
		(st_q.phase == PH_BURST && st_q.kind == K_RDCAL && mlane_float)
		|=> (mask_inversion_lane_oe_n == 2'h3))
		else $error("Mask lanes driven while they should float");

	chk_cal_invert: assert property ( // [RL2]
		(dq_oe_n == '0 && st_q.kind == K_RDCAL && $stable(st_q.inv_lower)
		&& $stable(st_q.inv_upper))
		|-> (dq_out == ({DQ_W{mask_inversion_lane_out[0]}}
		^ {st_q.inv_upper, st_q.inv_lower}))
		&& (mask_inversion_lane_out[0] == mask_inversion_lane_out[1]))
		else $error("Calibration lanes do not follow invert masks");

	chk_ptr_range: assert property ( // [RL13]
		st_q.wr_ptr <= LAST_ENTRY && st_q.rd_ptr <= LAST_ENTRY)
		else $error("FIFO pointer left the five entries");

	chk_read_adv: assert property ( // [RL16]
		(ck_rise && (cmd == CMD_READ || cmd == CMD_READ_AP)
		&& !cke_fall && !pin_rst_n_f)
		|=> st_q.wr_ptr == ptr_next($past(st_q.wr_ptr))
		&& st_q.rd_ptr == ptr_next($past(st_q.rd_ptr)))
		else $error("Array read did not advance both pointers");

	chk_ptr_reset: assert property ( // [RL14]
		(cke_fall || pin_rst_n_f) |=> st_q.wr_ptr == 3'h0
		&& st_q.rd_ptr == 3'h0)
		else $error("Pointers not cleared on power-down or reset pin");

	chk_latency_end: assert property ( // [RL23]
		(st_q.phase == PH_WAIT && st_q.cnt == 6'h00 && ck_rise
		&& !pin_rst_n_f)
		|=> st_q.phase == PH_BURST && st_q.beat == 4'h0
		##1 (dq_oe_n == '0 || st_q.kind == K_WRFIFO))
		else $error("Burst did not start when latency expired");

	chk_fifo_keep: assert property ( // [RL11]
		(st_q.phase != PH_BURST || st_q.kind != K_WRFIFO)
		|=> $stable(st_q.mem))
		else $error("FIFO contents changed outside a FIFO write");

	chk_pend_life: assert property ( // [RL7]
		(ck_rise && st_q.pend) |=> !st_q.pend || ($past(cmd) == CMD_MULTI))
		else $error("Training command outlived the next link edge");

	cov_rdcal: cover property (
		st_q.phase == PH_BURST && st_q.kind == K_RDCAL
		&& st_q.beat == LAST_BEAT);
	cov_wrfifo: cover property (
		st_q.phase == PH_WAIT && st_q.kind == K_WRFIFO);
	cov_rdfifo_wrap: cover property (
		ck_rise && cmd == CMD_CAS2 && st_q.pend
		&& st_q.pend_kind == K_RDFIFO && st_q.rd_ptr == LAST_ENTRY);
endmodule // dtf_training

// ==== tb_dram_dq_training_fifo.sv ====
// Self-checking bench for the training block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_dram_dq_training_fifo
	import dtf_pkg::*;
;
	logic             mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]       paddr, pat0, pat1, ml, mu;
	logic [31:0]      pwdata, prdata, rd;
	logic [3:0]       pstrb;
	logic             link_ck, link_cke, link_reset_n, err;
	logic [2:0]       link_cmd;
	logic [6:0]       link_op;
	logic [DQ_W-1:0]  dq_in, dq_out, dq_oe_n;
	logic [MASK_W-1:0] mask_in, mask_out, mask_oe_n;
	logic [LANES-1:0] d [16];
	logic [LANES-1:0] fifo [5][16];
	logic [7:0]       rv [9] = '{8'h5a, 8'h3c, 8'h55, 8'h55, 8'h00,
	                             8'h00, 8'h06, 8'h06, 8'h00};
	int               mismatches, n_compared, lat, wp, rp;

	dtf_training dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link_ck(link_ck),
		.link_cke(link_cke), .link_reset_n(link_reset_n),
		.link_cmd(link_cmd), .link_op(link_op), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.mask_inversion_lane_in(mask_in),
		.mask_inversion_lane_out(mask_out),
		.mask_inversion_lane_oe_n(mask_oe_n));

	dtf_ctrl_model ctl (.mclk(mclk), .link_ck(link_ck),
		.link_cke(link_cke), .link_reset_n(link_reset_n),
		.link_cmd(link_cmd), .link_op(link_op), .dq_in(dq_in),
		.mask_in(mask_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.mask_out(mask_out), .mask_oe_n(mask_oe_n));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Bus and sequence helpers
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] wd);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a hung wait
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Writes nw entries, then reads nr back against the reference
	task automatic fifo_rw(input int nw, input int nr);
		for (int n = 0; n < nw + nr; n++) begin
			if (n < nw) begin
				foreach (d[k]) d[k] = LANES'($urandom);
				fifo[wp] = d;
				wp = (wp + 1) % FIFO_DEPTH;
			end
			ctl.train(n < nw ? OP_WR_FIFO : OP_RD_FIFO, lat, n < nw, d);
			for (int k = 0; k < 16 && n >= nw; k++)
				`CHK(ctl.beats[3 + lat + k], fifo[rp][k])
			if (n >= nw)
				rp = (rp + 1) % FIFO_DEPTH;
		end
	endtask

	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		{mismatches, n_compared, wp, rp} = '0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		void'($urandom(32'hd44e));
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0000_0000);
			`CHK(rd, 32'(rv[i]))
		end
		apb(1'b0, 8'h24, 32'h0000_0000);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		// Write with all byte lanes disabled must be dropped
		pstrb <= 4'h0;
		apb(1'b1, ADDR_CAL_FIRST, 32'h0000_00ff);
		pstrb <= 4'hf;
		apb(1'b0, ADDR_CAL_FIRST, 32'h0000_0000);
		`CHK(rd, 32'(rv[0]))
		{pat0, pat1, ml, mu} = $urandom;
		lat = 1 + $urandom % 3;
		apb(1'b1, ADDR_CAL_FIRST, 32'(pat0));
		apb(1'b1, ADDR_CAL_SECOND, 32'(pat1));
		apb(1'b1, ADDR_INV_LOWER, 32'(ml));
		apb(1'b1, ADDR_INV_UPPER, 32'(mu));
		apb(1'b1, ADDR_RD_LAT, 32'(lat));
		apb(1'b1, ADDR_WR_LAT, 32'(lat));
		for (int c = 0; c < 8; c++) begin
			logic fl;
			logic b;
			fl = c[0] && c[2:1] == 2'b00;
			apb(1'b1, ADDR_MASK_CFG, {26'h000_0000, c[0], 5'h00});
			apb(1'b1, ADDR_INV_CFG, {24'h00_0000, c[2:1], 6'h00});
			ctl.train(OP_RD_CAL, lat, 1'b0, d);
			`CHK(ctl.oens[2 + lat], {LANES{1'b1}})
			`CHK(ctl.oens[lat + 20], {LANES{1'b1}})
			for (int k = 0; k < 16; k++) begin
				b = k < 8 ? pat0[k] : pat1[k - 8];
				`CHK(ctl.oens[3 + lat + k], {{2{fl}}, 16'h0000})
				`CHK(ctl.beats[3 + lat + k][15:0], {16{b}} ^ {mu, ml})
				if (!fl)
					`CHK(ctl.beats[3 + lat + k][17:16], {2{b}})
			end
		end
		foreach (rv[i]) begin
			if (i < 2) begin
				ctl.train(i ? 7'h44 : 7'h03, lat, 1'b0, d);
				`CHK(ctl.oens[3 + lat], {LANES{1'b1}})
			end
		end
		apb(1'b1, ADDR_MASK_CFG, 32'h0000_0000);
		apb(1'b1, ADDR_INV_CFG, 32'h0000_0000);
		fifo_rw(6, 6);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		`CHK(rd, 32'({1'b0, 3'(rp), 1'b0, 3'(wp)}))
		for (int p = 0; p < 2; p++) begin
			// Normal reads only once write training is over
			ctl.cyc(p ? CMD_READ_AP : CMD_READ, 7'h00, 1'b0, '0);
			wp = (wp + 1) % FIFO_DEPTH;
			rp = (rp + 1) % FIFO_DEPTH;
			repeat (2) ctl.cyc(CMD_DES, 7'h00, 1'b0, '0);
			apb(1'b0, ADDR_STATUS, 32'h0000_0000);
			`CHK(rd[7:0], {1'b0, 3'(rp), 1'b0, 3'(wp)})
			ctl.pulse(p[0]);
			wp = 0;
			rp = 0;
			repeat (3) ctl.cyc(CMD_DES, 7'h00, 1'b0, '0);
			apb(1'b0, ADDR_STATUS, 32'h0000_0000);
			`CHK(rd[7:0], 8'h00)
		end
		fifo_rw(2, 7);
		summarize();
	end
endmodule // tb_dram_dq_training_fifo
